// [pbr_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pbr_map.svh"

// Notes on behaviour
// R1: control bit 15 resets control bits and irq status
// R2: soft reset bit clears itself when done
// R3: control bit 14 enables mii loopback
// R4: control bit 11 reports register or pin powerdown
// R5: control bit 10 selects isolate mode
// R6: first identifier register is fixed, read-only
// R7: second identifier holds vendor, model, revision
// R8: status bit 7 latches irq, write-0 clears
// R9: pin polarity: 1 active low, 0 high
// R10: pin function: 1 irq output, 0 powerdown input
module pbr_regs #(
  parameter logic [15:0] VENDOR_ID_HIGH = 16'h0A5A, // arbitrary value
  parameter logic [5:0]  VENDOR_ID_LOW  = 6'h15,    // arbitrary value
  parameter logic [4:0]  MODEL_NUMBER   = 5'h03,    // arbitrary value
  parameter logic [4:0]  REVISION       = 5'h02,    // arbitrary value
  parameter int          SRST_CYCLES    = `PBR_SRST_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire pbr_pkg::pbr_req_s req,
  input  wire logic             link_up,
  input  wire logic             irq_event,
  input  wire logic             irq_or_sleep_pin_in,
  output var  logic             irq_or_sleep_pin_out,
  output var  logic             irq_or_sleep_pin_oe,
  output var  logic [15:0]      rd_data,
  output var  logic             rd_valid,
  output var  logic             loopback_en,
  output var  logic             isolate_en,
  output var  logic             power_down,
  output var  logic             digital_reset
);

  pbr_pkg::pbr_srst_e state_reg;
  logic [7:0]         cnt_reg;
  logic               pwdn_reg;
  logic               sts_irq_reg;
  logic [15:0]        gcfg_reg;
  logic               pin_meta_reg;
  logic               pin_sync_reg;
  logic               busy;
  logic               srst_start;
  logic               irq_set;
  logic               pin_sleep;
  logic               pwdn_now;
  logic               irq_active;
  logic [15:0]        rd_next;

  assign busy       = (state_reg == pbr_pkg::PBR_SRST);
  assign srst_start = req.wr && (req.addr == `PBR_ADDR_CTRL) && req.wdata[`PBR_CTRL_SRST] && !busy;
  assign irq_set    = irq_event && gcfg_reg[`PBR_GCFG_IEN];
  // pin only means powerdown while not used as irq output
  assign pin_sleep  = !gcfg_reg[`PBR_GCFG_OE] && (pin_sync_reg ^ gcfg_reg[`PBR_GCFG_POL]); // R10 R9
  assign pwdn_now   = pwdn_reg || pin_sleep;
  assign irq_active = sts_irq_reg || gcfg_reg[`PBR_GCFG_FORCE];

  always_ff @(posedge clock or posedge rst) begin
    // idle pin is high; a zero here would fake a powerdown after reset
    if (rst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= irq_or_sleep_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // soft reset sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= pbr_pkg::PBR_IDLE;
      cnt_reg       <= 8'h00;
      digital_reset <= 1'b0;
    end else begin
      case (state_reg)
        pbr_pkg::PBR_IDLE: begin
          cnt_reg <= 8'h00;
          if (srst_start) begin
            state_reg     <= pbr_pkg::PBR_SRST; // R1
            digital_reset <= 1'b1; // R1
          end
        end
        pbr_pkg::PBR_SRST: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(SRST_CYCLES - 1)) begin
            state_reg     <= pbr_pkg::PBR_IDLE; // R2
            digital_reset <= 1'b0; // R2
          end
        end
        default: begin
          state_reg     <= pbr_pkg::PBR_IDLE;
          digital_reset <= 1'b0;
        end
      endcase
    end
  end

  // control bits held at default throughout soft reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loopback_en <= 1'b0;
      isolate_en  <= 1'b0;
      pwdn_reg    <= 1'b0;
    end else if (srst_start || busy) begin
      loopback_en <= 1'b0; // R1
      isolate_en  <= 1'b0; // R1
      pwdn_reg    <= 1'b0; // R1
    end else if (req.wr && (req.addr == `PBR_ADDR_CTRL)) begin
      loopback_en <= req.wdata[`PBR_CTRL_LOOP]; // R3
      isolate_en  <= req.wdata[`PBR_CTRL_ISO]; // R5
      pwdn_reg    <= req.wdata[`PBR_CTRL_PWDN]; // R4
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= pwdn_now; // R4
    end
  end

  // set beats a same-cycle software clear; soft reset beats both
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sts_irq_reg <= 1'b0;
    end else if (srst_start || busy) begin
      sts_irq_reg <= 1'b0; // R1
    end else if (irq_set) begin
      sts_irq_reg <= 1'b1; // R8
    end else if (req.wr && (req.addr == `PBR_ADDR_STS) && !req.wdata[`PBR_STS_IRQ]) begin
      sts_irq_reg <= 1'b0; // R8
    end
  end

  // outside the soft reset range, so keeps its setting
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gcfg_reg <= `PBR_GCFG_RESET; // R9 R10
    end else if (req.wr && (req.addr == `PBR_ADDR_GCFG)) begin
      gcfg_reg <= req.wdata & `PBR_GCFG_WMASK;
    end
  end

  // registered pin drive costs one cycle of latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_or_sleep_pin_oe  <= 1'b0;
      irq_or_sleep_pin_out <= 1'b1;
    end else begin
      irq_or_sleep_pin_oe  <= gcfg_reg[`PBR_GCFG_OE]; // R10
      irq_or_sleep_pin_out <= (gcfg_reg[`PBR_GCFG_OE] && irq_active) ^ gcfg_reg[`PBR_GCFG_POL]; // R9
    end
  end

  always_comb begin
    rd_next = 16'h0000;
    if (req.addr == `PBR_ADDR_CTRL) begin
      rd_next[`PBR_CTRL_SRST] = busy; // R2
      rd_next[`PBR_CTRL_LOOP] = loopback_en;
      rd_next[`PBR_CTRL_PWDN] = pwdn_now; // R4
      rd_next[`PBR_CTRL_ISO]  = isolate_en;
    end else if (req.addr == `PBR_ADDR_ID_HI) begin
      rd_next = VENDOR_ID_HIGH; // R6
    end else if (req.addr == `PBR_ADDR_ID_LO) begin
      rd_next = {VENDOR_ID_LOW, MODEL_NUMBER, REVISION}; // R7
    end else if (req.addr == `PBR_ADDR_STS) begin
      rd_next[`PBR_STS_IRQ]  = sts_irq_reg; // R8
      rd_next[`PBR_STS_LINK] = link_up;
    end else if (req.addr == `PBR_ADDR_GCFG) begin
      rd_next = gcfg_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= rd_next;
      end
    end
  end

  localparam int SRST_LIM = SRST_CYCLES + 1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_SRST_ENTER: assert property (srst_start |=> digital_reset && !loopback_en && !isolate_en) // R1
    else $error("soft reset did not take effect");
  AST_SRST_IRQ: assert property (srst_start |=> !sts_irq_reg) // R1
    else $error("irq status survived soft reset");
  AST_SRST_DONE: assert property (srst_start |-> ##[1:SRST_LIM] (!digital_reset && !busy)) // R2
    else $error("soft reset bit did not clear");
  AST_LOOP_WR: assert property (req.wr && req.addr == `PBR_ADDR_CTRL && !busy && !req.wdata[15]
                                |=> loopback_en == $past(req.wdata[14])) // R3
    else $error("loopback bit not stored");
  AST_PWDN_PIN: assert property (pin_sleep |=> power_down) // R4
    else $error("pin powerdown not reported");
  AST_ISO_WR: assert property (req.wr && req.addr == `PBR_ADDR_CTRL && !busy && !req.wdata[15]
                               |=> isolate_en == $past(req.wdata[10])) // R5
    else $error("isolate bit not stored");
  AST_ID_HI: assert property (req.rd && req.addr == `PBR_ADDR_ID_HI |=> rd_valid && rd_data == VENDOR_ID_HIGH) // R6
    else $error("identifier high wrong");
  AST_ID_LO: assert property (req.rd && req.addr == `PBR_ADDR_ID_LO
                              |=> rd_valid && rd_data[15:10] == VENDOR_ID_LOW
                                  && rd_data[9:5] == MODEL_NUMBER && rd_data[4:0] == REVISION) // R7
    else $error("identifier low wrong");
  AST_IRQ_SET: assert property (irq_set && !busy && !srst_start |=> sts_irq_reg) // R8
    else $error("irq event not latched");
  AST_PIN_POL: assert property (gcfg_reg[`PBR_GCFG_OE] && sts_irq_reg
                                |=> irq_or_sleep_pin_out != $past(gcfg_reg[`PBR_GCFG_POL])) // R9
    else $error("irq pin wrong level");
  AST_PIN_DIR: assert property (!gcfg_reg[`PBR_GCFG_OE] |=> !irq_or_sleep_pin_oe) // R10
    else $error("pin driven while powerdown input");

  COV_SRST: cover property (srst_start ##1 busy [*2] ##[1:SRST_LIM] !busy);
  COV_IRQ_CLR: cover property (sts_irq_reg ##1 (req.wr && req.addr == `PBR_ADDR_STS) ##1 !sts_irq_reg);
  COV_PIN_IRQ: cover property (irq_or_sleep_pin_oe && sts_irq_reg);
  COV_PIN_SLEEP: cover property (pin_sleep ##1 power_down);

endmodule // pbr_regs

`default_nettype wire

// [pbr_map.svh]
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH

`define PBR_ADDR_CTRL    5'h00
`define PBR_ADDR_ID_HI   5'h02
`define PBR_ADDR_ID_LO   5'h03
`define PBR_ADDR_STS     5'h10
`define PBR_ADDR_GCFG    5'h11

`define PBR_CTRL_SRST    15
`define PBR_CTRL_LOOP    14
`define PBR_CTRL_PWDN    11
`define PBR_CTRL_ISO     10

`define PBR_STS_IRQ      7
`define PBR_STS_LINK     0

`define PBR_GCFG_POL     3
`define PBR_GCFG_FORCE   2
`define PBR_GCFG_IEN     1
`define PBR_GCFG_OE      0
`define PBR_GCFG_RESET   16'h002A
`define PBR_GCFG_WMASK   16'h006F

`define PBR_SRST_CYCLES  8

`endif

// [pbr_pkg.sv]
package pbr_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pbr_req_s;

  typedef enum logic [1:0] {
    PBR_IDLE = 2'b01,
    PBR_SRST = 2'b10
  } pbr_srst_e;

endpackage

// [pbr_mgmt_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pbr_mgmt_model (
  input  wire logic             clock,
  input  wire logic             rd_valid,
  input  wire logic [15:0]      rd_data,
  output var  pbr_pkg::pbr_req_s req
);
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'h0;
  endtask
  // answer only lives one cycle, so it is taken mid-cycle right after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clock);
    req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    req.rd <= 1'h0;
    @(negedge clock);
    v = rd_valid;
    d = rd_data;
  endtask
endmodule // pbr_mgmt_model
`default_nettype wire

// [test_phy_basic_control_status_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pbr_map.svh"
module test_phy_basic_control_status_regs;
  localparam logic [15:0] VH = 16'h1234; // arbitrary value
  logic              clock, rst, link_up, irq_event, pin_drv, rd_valid, pin_out, pin_oe;
  logic              loopback_en, isolate_en, power_down, digital_reset;
  logic [15:0]       rd_data;
  pbr_pkg::pbr_req_s req;
  wire logic         pin = pin_oe ? pin_out : pin_drv;
  int                n_errors = 0, num_checks = 0, cycles = 0;

  pbr_mgmt_model mgr (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data), .req(req));
  pbr_regs #(.VENDOR_ID_HIGH(VH), .VENDOR_ID_LOW(6'h2A), .MODEL_NUMBER(5'h11), .REVISION(5'h07),
    .SRST_CYCLES(4)) uut (.clock(clock), .rst(rst), .req(req), .link_up(link_up), .irq_event(irq_event),
    .irq_or_sleep_pin_in(pin), .irq_or_sleep_pin_out(pin_out), .irq_or_sleep_pin_oe(pin_oe),
    .rd_data(rd_data), .rd_valid(rd_valid), .loopback_en(loopback_en), .isolate_en(isolate_en),
    .power_down(power_down), .digital_reset(digital_reset));

  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    mgr.rd(a, d, v);
    chk("rd_valid", 16'h0001, {15'h0000, v});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic pulse_irq();
    @(posedge clock) irq_event <= 1'h1;
    @(posedge clock) irq_event <= 1'h0;
  endtask

  task automatic t_ids();
    rchk(`PBR_ADDR_ID_HI, VH);
    mgr.wr(`PBR_ADDR_ID_HI, 16'h0000);
    mgr.wr(`PBR_ADDR_ID_LO, 16'h0000);
    rchk(`PBR_ADDR_ID_HI, VH);
    rchk(`PBR_ADDR_ID_LO, 16'hAA27);
    rchk(5'h05, 16'h0000);
  endtask
  task automatic t_ctrl();
    rchk(`PBR_ADDR_CTRL, 16'h0000);
    mgr.wr(`PBR_ADDR_CTRL, 16'h4400);
    repeat (2) @(negedge clock);
    chk("loopback_en", 16'h0001, {15'h0000, loopback_en});
    chk("isolate_en", 16'h0001, {15'h0000, isolate_en});
    rchk(`PBR_ADDR_CTRL, 16'h4400);
    mgr.wr(`PBR_ADDR_CTRL, 16'h0800);
    repeat (2) @(negedge clock);
    chk("power_down", 16'h0001, {15'h0000, power_down});
    chk("isolate_en", 16'h0000, {15'h0000, isolate_en});
    rchk(`PBR_ADDR_CTRL, 16'h0800);
    mgr.wr(`PBR_ADDR_CTRL, 16'h0000);
  endtask
  task automatic t_irq();
    @(posedge clock) link_up <= 1'h1;
    pulse_irq();
    rchk(`PBR_ADDR_STS, 16'h0081);
    mgr.wr(`PBR_ADDR_STS, 16'h0080);
    rchk(`PBR_ADDR_STS, 16'h0081);
    mgr.wr(`PBR_ADDR_STS, 16'h0000);
    rchk(`PBR_ADDR_STS, 16'h0001);
    // event and clear land on the same edge: the event must win
    fork
      mgr.wr(`PBR_ADDR_STS, 16'h0000);
      pulse_irq();
    join
    rchk(`PBR_ADDR_STS, 16'h0081);
  endtask
  // bit 14 also set so a reset that misses the loopback bit shows
  task automatic t_srst();
    @(posedge clock) link_up <= 1'h0;
    pulse_irq();
    mgr.wr(`PBR_ADDR_CTRL, 16'hC400);
    @(negedge clock);
    chk("digital_reset", 16'h0001, {15'h0000, digital_reset});
    chk("loopback_en", 16'h0000, {15'h0000, loopback_en});
    rchk(`PBR_ADDR_CTRL, 16'h8000);
    repeat (6) @(posedge clock);
    rchk(`PBR_ADDR_CTRL, 16'h0000);
    rchk(`PBR_ADDR_STS, 16'h0000);
  endtask
  // config reads its reset value after soft reset; force drives the pin with no latched event
  task automatic t_cfg();
    rchk(`PBR_ADDR_GCFG, 16'h002A);
    mgr.wr(`PBR_ADDR_GCFG, 16'h0028);
    pulse_irq();
    rchk(`PBR_ADDR_STS, 16'h0000);
    mgr.wr(`PBR_ADDR_GCFG, 16'hFF2D);
    rchk(`PBR_ADDR_GCFG, 16'h002D);
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    chk("pin_out", 16'h0000, {15'h0000, pin_out});
  endtask
  task automatic t_pin();
    mgr.wr(`PBR_ADDR_GCFG, 16'h002B);
    pulse_irq();
    repeat (2) @(negedge clock);
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    chk("pin_out", 16'h0000, {15'h0000, pin_out});
    mgr.wr(`PBR_ADDR_GCFG, 16'h0023);
    repeat (2) @(negedge clock);
    chk("pin_out", 16'h0001, {15'h0000, pin_out});
    mgr.wr(`PBR_ADDR_STS, 16'h0000);
    mgr.wr(`PBR_ADDR_GCFG, 16'h002A);
    @(posedge clock) pin_drv <= 1'h0;
    repeat (4) @(negedge clock);
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    chk("power_down", 16'h0001, {15'h0000, power_down});
    rchk(`PBR_ADDR_CTRL, 16'h0800);
    @(posedge clock) pin_drv <= 1'h1;
    repeat (4) @(negedge clock);
    chk("power_down", 16'h0000, {15'h0000, power_down});
  endtask

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // ceiling well above the hundred or so cycles the scenarios need
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    rst = 1'h1;
    link_up = 1'h0;
    irq_event = 1'h0;
    pin_drv = 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(negedge clock);
    chk("power_down", 16'h0000, {15'h0000, power_down});
    chk("pin_out", 16'h0001, {15'h0000, pin_out});
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    chk("digital_reset", 16'h0000, {15'h0000, digital_reset});
    t_ids();
    t_ctrl();
    t_irq();
    t_srst();
    t_cfg();
    t_pin();
    final_report();
  end
endmodule // test_phy_basic_control_status_regs
`default_nettype wire
